// ### core/fault_protection_manager.sv
// Fault supervisor that decides when the flyback gate drive may run.
// Behaviour
// - Upper fault-pin flag latches the controller off.
// - Lower fault-pin flag disables the controller as over-temperature.
// - With neither pin flag, switching continues untouched by the pin.
// - Pin flags count only after staying asserted beyond the 30 us blank.
// - Pin latch survives start levels; cleared by supply reset or discharge.
// - Over-temperature pull-up stays off until supply first reaches start level.
// - Lower pin flag is ignored for the whole soft-start.
// - Over-temperature latches, or recovers after release, timer and start level.
// - Overload timer integrates up with overload and down without; 160 ms.
// - Overload expiry latches off or enters auto-recovery, per option.
// - Abnormal overcurrent flag blanked 125 ns after each turn-on.
// - Four consecutive abnormal overcurrent detections latch off.
// - A clean gate pulse resets the abnormal overcurrent counter.
// - Current-sense open flag disables the controller.
// - Every gate pulse ends by 32 us on-time.
// - Armed demag input disables valley timeout; next pulse waits for demag.
// - Supply overvoltage stops the gate at once and latches.
// - Die over-temperature disables the controller, non-latching.
// - After die shutdown, restart needs cooling by the hysteresis and start level.
// - Die shutdown also clears on supply reset or line removal.
// - A fresh start at the start level happens only with no fault active, except a lower pin flag set for auto-recovery.
// - Auto-recovery stops the gate, runs 1.2 s, restarts at next start level.
// - A latching fault never restarts at later start levels.
//
// Chosen here: the address map and the APB register port.
`timescale 1ns/10ps
`include "fpm_consts.svh"
`default_nettype none
module fault_protection_manager #(
  parameter logic [31:0] OVLD_CYCLES = `FPM_OVLD_CYC,
  parameter logic [31:0] AUTOREC_CYCLES = `FPM_AUTOREC_CYC
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic pin_upper_flag,
  input wire logic pin_lower_flag,
  input wire logic pin_release_flag,
  input wire logic overload_flag,
  input wire logic abnormal_current_flag,
  input wire logic cs_open_flag,
  input wire logic supply_ovp_flag,
  input wire logic die_hot_flag,
  input wire logic die_cooled_flag,
  input wire logic demag_armed_flag,
  input wire logic demag_detect_flag,
  input wire logic supply_start_flag,
  input wire logic supply_reset_flag,
  input wire logic line_removal_flag,
  input wire logic soft_start_active,
  input wire logic drive_request,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic gate_drive_pulse,
  output logic overtemp_pullup_source,
  output logic valley_timer_en,
  output logic controller_on
);
  import fpm_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  flag_vec_t raw_flags;
  flag_vec_t sync_flags;
  logic s_upper, s_lower, s_release, s_ovld, s_abnormal_overcurrent_detect, s_csopen, s_vovp;
  logic s_hot, s_cool, s_armed, s_demag, s_start, s_vreset, s_linerm;

  assign raw_flags = {pin_upper_flag, pin_lower_flag, pin_release_flag, overload_flag,
                      abnormal_current_flag, cs_open_flag, supply_ovp_flag, die_hot_flag,
                      die_cooled_flag, demag_armed_flag, demag_detect_flag,
                      supply_start_flag, supply_reset_flag, line_removal_flag};

  flag_sync u_sync (
    .clk(clk),
    .reset_n(reset_n),
    .d(raw_flags),
    .q(sync_flags)
  );

  assign {s_upper, s_lower, s_release, s_ovld, s_abnormal_overcurrent_detect, s_csopen, s_vovp,
          s_hot, s_cool, s_armed, s_demag, s_start, s_vreset, s_linerm} = sync_flags;

  ////////////////////////////////////////////////////////////////////////////////
  fpm_state_t state_reg;
  logic [1:0] ctrl_reg;
  logic [9:0] upper_cnt_reg, lower_cnt_reg;
  logic upper_det, lower_det, lower_qual;
  logic [31:0] ovld_cnt_reg, ar_cnt_reg;
  logic ovld_expired, ar_done_reg, otp_wait_reg, tsd_reg, start_prev_reg, start_rise;
  logic [9:0] on_cnt_reg;
  logic abnormal_overcurrent_detect_hit_reg, wait_demag_reg, pulse_end, pulse_start;
  logic [2:0] abnormal_overcurrent_detect_cnt_reg;
  logic abnormal_overcurrent_detect_trip, latch_evt, ar_evt, nonlatch_fault, clear_evt;

  assign start_rise = s_start & ~start_prev_reg;
  assign clear_evt = s_vreset | s_linerm;

  ////////////////////////////////////////////////////////////////////////////////
  // pull-up source enable.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      overtemp_pullup_source <= 1'b0;
    end else if (s_vreset) begin
      overtemp_pullup_source <= 1'b0;
    end else if (s_start) begin
      overtemp_pullup_source <= 1'b1;
    end
  end

  // lower flag masked during soft-start and while the source is off.
  assign lower_qual = s_lower & ~soft_start_active & overtemp_pullup_source;

  // continuous-assertion blanking of both pin levels.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      upper_cnt_reg <= '0;
      lower_cnt_reg <= '0;
    end else begin
      if (!s_upper) begin
        upper_cnt_reg <= '0;
      end else if (!upper_det) begin
        upper_cnt_reg <= upper_cnt_reg + 10'h001;
      end
      if (!lower_qual) begin
        lower_cnt_reg <= '0;
      end else if (!lower_det) begin
        lower_cnt_reg <= lower_cnt_reg + 10'h001;
      end
    end
  end

  assign upper_det = upper_cnt_reg > 10'(`FPM_BLANK_CYC);
  assign lower_det = lower_cnt_reg > 10'(`FPM_BLANK_CYC);

  ////////////////////////////////////////////////////////////////////////////////
  // integrating overload timer.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ovld_cnt_reg <= '0;
    end else if (state_reg != ST_RUN) begin
      ovld_cnt_reg <= '0;
    end else if (s_ovld && !ovld_expired) begin
      ovld_cnt_reg <= ovld_cnt_reg + 32'h1;
    end else if (!s_ovld && ovld_cnt_reg != 32'h0) begin
      ovld_cnt_reg <= ovld_cnt_reg - 32'h1;
    end
  end

  assign ovld_expired = ovld_cnt_reg >= OVLD_CYCLES;

  ////////////////////////////////////////////////////////////////////////////////
  assign pulse_start = (state_reg == ST_RUN) && drive_request && !gate_drive_pulse &&
                       (!wait_demag_reg || s_demag) && !latch_evt;
  assign pulse_end = gate_drive_pulse && (!drive_request || state_reg != ST_RUN ||
                     s_vovp || on_cnt_reg >= 10'(`FPM_MAXON_CYC - 1));

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      gate_drive_pulse <= 1'b0;
      on_cnt_reg <= '0;
    end else if (pulse_end) begin
      gate_drive_pulse <= 1'b0;
      on_cnt_reg <= '0;
    end else if (pulse_start) begin
      gate_drive_pulse <= 1'b1;
      on_cnt_reg <= 10'h001;
    end else if (gate_drive_pulse) begin
      on_cnt_reg <= on_cnt_reg + 10'h001;
    end
  end

  // valley timeout hold and demag wait.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      valley_timer_en <= 1'b0;
      wait_demag_reg <= 1'b0;
    end else begin
      valley_timer_en <= ~s_armed;
      if (pulse_start) begin
        wait_demag_reg <= 1'b0;
      end else if (!gate_drive_pulse && s_armed) begin
        wait_demag_reg <= 1'b1;
      end
    end
  end

  // short blanking, counted past the synchroniser delay.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      abnormal_overcurrent_detect_hit_reg <= 1'b0;
    end else if (!gate_drive_pulse) begin
      abnormal_overcurrent_detect_hit_reg <= 1'b0;
    end else if (s_abnormal_overcurrent_detect && on_cnt_reg >= 10'(`FPM_LEB2_CYC + `FPM_SYNC_CYC)) begin
      abnormal_overcurrent_detect_hit_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      abnormal_overcurrent_detect_cnt_reg <= '0;
    end else if (s_vreset || state_reg == ST_LATCHED) begin
      abnormal_overcurrent_detect_cnt_reg <= '0;
    end else if (pulse_end) begin
      if (abnormal_overcurrent_detect_hit_reg) begin
        abnormal_overcurrent_detect_cnt_reg <= abnormal_overcurrent_detect_cnt_reg + 3'h1;
      end else begin
        abnormal_overcurrent_detect_cnt_reg <= '0;
      end
    end
  end

  assign abnormal_overcurrent_detect_trip = abnormal_overcurrent_detect_cnt_reg >= `FPM_ABNORMAL_OVERCURRENT_DETECT_LIMIT;

  ////////////////////////////////////////////////////////////////////////////////
  // die shutdown flag.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tsd_reg <= 1'b0;
    end else if (s_hot) begin
      tsd_reg <= 1'b1;
    end else if (s_cool || clear_evt) begin
      // supply reset or line removal clears it.
      tsd_reg <= 1'b0;
    end
  end

  // upper pin, supply overvoltage, abnormal overcurrent, latch options.
  assign latch_evt = upper_det | s_vovp | abnormal_overcurrent_detect_trip |
                     (lower_det & ctrl_reg[`FPM_CTRL_OTP_LATCH]) |
                     (ovld_expired & ctrl_reg[`FPM_CTRL_OVLD_LATCH]);
  // lower pin and overload go to auto-recovery otherwise.
  assign ar_evt = (lower_det & ~ctrl_reg[`FPM_CTRL_OTP_LATCH]) |
                  (ovld_expired & ~ctrl_reg[`FPM_CTRL_OVLD_LATCH]);
  assign nonlatch_fault = tsd_reg | s_hot | s_csopen;

  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= ST_WAIT;
      start_prev_reg <= 1'b0;
      otp_wait_reg <= 1'b0;
    end else begin
      start_prev_reg <= s_start;
      if (s_vreset) begin
        state_reg <= ST_WAIT;
        otp_wait_reg <= 1'b0;
      end else begin
        unique case (state_reg)
          // start only when nothing but an auto-recovery lower pin flag is active.
          ST_WAIT: begin
            if (latch_evt) begin
              state_reg <= ST_LATCHED;
            end else if (s_start && !nonlatch_fault) begin
              state_reg <= ST_RUN;
            end
          end
          // run untouched while the pin stays in range.
          ST_RUN: begin
            if (latch_evt) begin
              state_reg <= ST_LATCHED;
            end else if (ar_evt) begin
              state_reg <= ST_RECOVER;
              otp_wait_reg <= lower_det;
            end else if (nonlatch_fault) begin
              state_reg <= ST_WAIT;
            end
          end
          // only a clear event leaves the latch.
          ST_LATCHED: begin
            if (clear_evt) begin
              state_reg <= ST_WAIT;
            end
          end
          // restart at the start level after the timer.
          ST_RECOVER: begin
            if (latch_evt) begin
              state_reg <= ST_LATCHED;
            end else if (ar_done_reg && start_rise && !nonlatch_fault &&
                         (!otp_wait_reg || s_release)) begin
              state_reg <= ST_RUN;
              otp_wait_reg <= 1'b0;
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ar_cnt_reg <= '0;
      ar_done_reg <= 1'b0;
    end else if (state_reg != ST_RECOVER) begin
      ar_cnt_reg <= '0;
      ar_done_reg <= 1'b0;
    end else if (ar_cnt_reg >= AUTOREC_CYCLES - 32'h1) begin
      ar_done_reg <= 1'b1;
    end else begin
      ar_cnt_reg <= ar_cnt_reg + 32'h1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      controller_on <= 1'b0;
    end else begin
      controller_on <= (state_reg == ST_RUN);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  logic setup_ph, wr_acc, hit_ctrl, hit_stat;
  logic [31:0] stat_word;

  assign setup_ph = psel & ~penable;
  assign wr_acc = psel & penable & pready & pwrite;
  assign hit_ctrl = paddr == `FPM_CTRL_OFS;
  assign hit_stat = paddr == `FPM_STAT_OFS;

  always_comb begin
    stat_word = '0;
    stat_word[`FPM_ST_STATE +: 2] = state_reg;
    stat_word[`FPM_ST_GATE] = gate_drive_pulse;
    stat_word[`FPM_ST_OTPSRC] = overtemp_pullup_source;
    stat_word[`FPM_ST_TSD] = tsd_reg;
    stat_word[`FPM_ST_OTPWAIT] = otp_wait_reg;
    stat_word[`FPM_ST_TIMER_DONE] = ar_done_reg;
    stat_word[`FPM_ST_ABNORMAL_OVERCURRENT_DETECT +: 3] = abnormal_overcurrent_detect_cnt_reg;
  end

  // Answers in the first access cycle; unmapped or status writes report an error.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else begin
      pready <= setup_ph;
      pslverr <= setup_ph & ~(hit_ctrl | (hit_stat & ~pwrite));
      if (setup_ph && !pwrite) begin
        prdata <= hit_ctrl ? {30'h0, ctrl_reg} : (hit_stat ? stat_word : 32'h0);
      end else if (!psel) begin
        prdata <= '0;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_reg <= `FPM_CTRL_RST;
    end else if (wr_acc && hit_ctrl) begin
      ctrl_reg <= pwdata[1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  a_upper_latch: assert property (@(posedge clk) disable iff (!reset_n)
    (upper_det && !s_vreset) |=> state_reg == ST_LATCHED)
    else $error("upper pin level did not latch");
  a_blank_short: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(s_upper) |-> !upper_det [*8])
    else $error("upper pin accepted inside blanking");
  a_gate_maxon: assert property (@(posedge clk) disable iff (!reset_n)
    gate_drive_pulse |-> on_cnt_reg <= 10'(`FPM_MAXON_CYC))
    else $error("gate pulse exceeded on-time limit");
  a_abnormal_overcurrent_detect_four: assert property (@(posedge clk) disable iff (!reset_n)
    (abnormal_overcurrent_detect_trip && !s_vreset) |=> state_reg == ST_LATCHED && !gate_drive_pulse)
    else $error("four abnormal detections did not latch");
  a_latch_holds: assert property (@(posedge clk) disable iff (!reset_n)
    (state_reg == ST_LATCHED && !clear_evt) |=> state_reg == ST_LATCHED)
    else $error("latched fault restarted");
  a_otp_src_off: assert property (@(posedge clk) disable iff (!reset_n)
    !overtemp_pullup_source |-> !lower_det)
    else $error("lower level acted with source off");
  a_vovp_gate: assert property (@(posedge clk) disable iff (!reset_n)
    s_vovp |=> !gate_drive_pulse)
    else $error("gate ran during supply overvoltage");
  a_tsd_stop: assert property (@(posedge clk) disable iff (!reset_n)
    (state_reg == ST_RUN && s_hot && !latch_evt && !ar_evt && !s_vreset)
      |=> state_reg == ST_WAIT ##1 !controller_on)
    else $error("die shutdown left controller on");
  a_soft_mask: assert property (@(posedge clk) disable iff (!reset_n)
    soft_start_active |=> lower_cnt_reg == 10'h0)
    else $error("lower level counted in soft-start");
  c_latch: cover property (@(posedge clk) disable iff (!reset_n)
    state_reg == ST_RUN ##1 state_reg == ST_LATCHED);
  c_recover: cover property (@(posedge clk) disable iff (!reset_n)
    state_reg == ST_RECOVER ##1 state_reg == ST_RUN);
  c_maxon: cover property (@(posedge clk) disable iff (!reset_n)
    gate_drive_pulse && on_cnt_reg == 10'(`FPM_MAXON_CYC - 1));
endmodule : fault_protection_manager
`default_nettype wire

// ### core/flag_sync.sv
// Two-stage synchroniser for the comparator flags.
`timescale 1ns/10ps
`default_nettype none
module flag_sync (
  input wire logic clk,
  input wire logic reset_n,
  input wire fpm_pkg::flag_vec_t d,
  output fpm_pkg::flag_vec_t q
);
  import fpm_pkg::*;
  flag_vec_t meta_reg;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_reg <= '0;
      q <= '0;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule : flag_sync
`default_nettype wire

// ### core/fpm_consts.svh
// Timing counts, register offsets, field positions and reset values of the fault manager.
`ifndef FPM_CONSTS_SVH
`define FPM_CONSTS_SVH

`define FPM_CLK_NS 50
`define FPM_BLANK_NS 30000
`define FPM_BLANK_CYC ((`FPM_BLANK_NS + `FPM_CLK_NS - 1) / `FPM_CLK_NS)
`define FPM_LEB2_NS 125
`define FPM_LEB2_CYC ((`FPM_LEB2_NS + `FPM_CLK_NS - 1) / `FPM_CLK_NS)
`define FPM_SYNC_CYC 2
`define FPM_MAXON_NS 32000
`define FPM_MAXON_CYC (`FPM_MAXON_NS / `FPM_CLK_NS)
`define FPM_OVLD_MS 160
`define FPM_OVLD_CYC (`FPM_OVLD_MS * 1000000 / `FPM_CLK_NS)
`define FPM_AUTOREC_MS 1200
`define FPM_AUTOREC_CYC (`FPM_AUTOREC_MS * 1000000 / `FPM_CLK_NS)
`define FPM_ABNORMAL_OVERCURRENT_DETECT_LIMIT 3'h4
`define FPM_NFLAGS 14

`define FPM_CTRL_OFS 12'h000
`define FPM_STAT_OFS 12'h004
`define FPM_CTRL_RST 2'h0
`define FPM_CTRL_OTP_LATCH 0
`define FPM_CTRL_OVLD_LATCH 1

`define FPM_ST_STATE 0
`define FPM_ST_GATE 2
`define FPM_ST_OTPSRC 3
`define FPM_ST_TSD 4
`define FPM_ST_OTPWAIT 5
`define FPM_ST_TIMER_DONE 6
`define FPM_ST_ABNORMAL_OVERCURRENT_DETECT 8

`endif

// ### core/fpm_pkg.sv
// Types shared by the fault manager files.
`include "fpm_consts.svh"
package fpm_pkg;
  typedef enum logic [1:0] {
    ST_WAIT = 2'b00,
    ST_RUN = 2'b01,
    ST_LATCHED = 2'b10,
    ST_RECOVER = 2'b11
  } fpm_state_t;
  typedef logic [`FPM_NFLAGS-1:0] flag_vec_t;
endpackage : fpm_pkg

// ### test/fpm_analog_model.sv
// Behavioural model of the comparators and power stage around the fault manager.
`timescale 1ns/10ps
`default_nettype none
module fpm_analog_model #(
  parameter int RELEASE_MV = 1000
) (
  input wire logic gate_drive_pulse,
  input wire logic overtemp_pullup_source,
  output logic pin_upper_flag,
  output logic pin_lower_flag,
  output logic pin_release_flag,
  output logic overload_flag,
  output logic abnormal_current_flag,
  output logic cs_open_flag,
  output logic supply_ovp_flag,
  output logic die_hot_flag,
  output logic die_cooled_flag,
  output logic demag_armed_flag,
  output logic demag_detect_flag,
  output logic supply_start_flag,
  output logic supply_reset_flag,
  output logic line_removal_flag
);
  int pin_mv = 1500;
  logic ovld = 1'b0, abnormal_overcurrent_detect = 1'b0, csopen = 1'b0, ovp = 1'b0, hot = 1'b0, cooled = 1'b0;
  logic armed = 1'b0, detect = 1'b0, start = 1'b0, sreset = 1'b0, lremove = 1'b0;
  assign pin_upper_flag = pin_mv > 3000;
  // Without the pull-up the pin sits at ground and reads low.
  assign pin_lower_flag = !overtemp_pullup_source || pin_mv < 400;
  assign pin_release_flag = overtemp_pullup_source && pin_mv > RELEASE_MV;
  // Abnormal current shows only while the switch conducts.
  assign abnormal_current_flag = gate_drive_pulse && abnormal_overcurrent_detect;
  assign overload_flag = ovld;
  assign cs_open_flag = csopen;
  assign supply_ovp_flag = ovp;
  assign die_hot_flag = hot;
  assign die_cooled_flag = cooled;
  assign demag_armed_flag = armed;
  assign demag_detect_flag = detect;
  assign supply_start_flag = start;
  assign supply_reset_flag = sreset;
  assign line_removal_flag = lremove;
endmodule : fpm_analog_model
`default_nettype wire

// ### test/tb_top.sv
// Self-checking testbench of the fault manager.
`timescale 1ns/10ps
`include "fpm_consts.svh"
`default_nettype none
module tb_top;
  import fpm_pkg::*;
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin failures++; \
  $display("mismatch at %0t: got %0h expected %0h", $time, got, exp); end end
  logic clk = 1'b0, reset_n = 1'b0, soft_start_active = 1'b0, drive_request = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, pslverr, gate_drive_pulse, overtemp_pullup_source, valley_timer_en;
  logic controller_on, e;
  wire logic pin_upper_flag, pin_lower_flag, pin_release_flag, overload_flag;
  wire logic abnormal_current_flag, cs_open_flag, supply_ovp_flag, die_hot_flag;
  wire logic die_cooled_flag, demag_armed_flag, demag_detect_flag, supply_start_flag;
  wire logic supply_reset_flag, line_removal_flag;
  int failures = 0, n_compared = 0, cnt;
  fault_protection_manager #(.OVLD_CYCLES(32'd200), .AUTOREC_CYCLES(32'd300)) u_dut (
    .clk, .reset_n, .pin_upper_flag, .pin_lower_flag, .pin_release_flag, .overload_flag,
    .abnormal_current_flag, .cs_open_flag, .supply_ovp_flag, .die_hot_flag, .die_cooled_flag,
    .demag_armed_flag, .demag_detect_flag, .supply_start_flag, .supply_reset_flag,
    .line_removal_flag, .soft_start_active, .drive_request, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .gate_drive_pulse, .overtemp_pullup_source,
    .valley_timer_en, .controller_on);
  fpm_analog_model u_pm (.gate_drive_pulse, .overtemp_pullup_source, .pin_upper_flag,
    .pin_lower_flag, .pin_release_flag, .overload_flag, .abnormal_current_flag, .cs_open_flag,
    .supply_ovp_flag, .die_hot_flag, .die_cooled_flag, .demag_armed_flag, .demag_detect_flag,
    .supply_start_flag, .supply_reset_flag, .line_removal_flag);
  initial begin
    forever #25 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) failures++;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task expect_on(input logic v, input int lim);
    int k;
    k = 0;
    while (controller_on !== v && k < lim) begin
      @(posedge clk);
      k++;
    end
    `CHK(controller_on, v)
  endtask : expect_on
  task state_is(input fpm_state_t s);
    apb(1'b0, `FPM_STAT_OFS, 32'h0);
    `CHK(r[1:0], s)
  endtask : state_is
  task run_up;
    u_pm.start <= 1'b1;
    u_pm.sreset <= 1'b1;
    cyc(4);
    u_pm.sreset <= 1'b0;
    expect_on(1'b1, 20);
  endtask : run_up
  task pulse(input int n);
    drive_request <= 1'b1;
    cyc(n);
    drive_request <= 1'b0;
    cyc(5);
  endtask : pulse
  task toggle_start;
    u_pm.start <= 1'b0;
    cyc(5);
    u_pm.start <= 1'b1;
  endtask : toggle_start
  task final_report;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : final_report
  ////////////////////////////////////////////////////////////////////////////
  task t_regs;
    `CHK(overtemp_pullup_source, 1'b0)
    `CHK(controller_on, 1'b0)
    apb(1'b0, `FPM_CTRL_OFS, 32'h0);
    `CHK(r, {30'h0, `FPM_CTRL_RST})
    apb(1'b1, `FPM_CTRL_OFS, 32'hFFFFFFFF);
    apb(1'b0, `FPM_CTRL_OFS, 32'h0);
    `CHK(r, 32'h00000003)
    apb(1'b1, `FPM_STAT_OFS, 32'h0);
    `CHK(e, 1'b1)
    apb(1'b0, 12'h008, 32'h0);
    `CHK(e, 1'b1)
    apb(1'b1, `FPM_CTRL_OFS, 32'h0);
    u_pm.start <= 1'b1;
    expect_on(1'b1, 20);
    `CHK(overtemp_pullup_source, 1'b1)
    $display("test regs and power-up done");
  endtask : t_regs
  task t_gate;
    drive_request <= 1'b1;
    cyc(3);
    cnt = 0;
    while (gate_drive_pulse === 1'b1 && cnt < 1000) begin
      @(posedge clk);
      cnt++;
    end
    drive_request <= 1'b0;
    `CHK(cnt inside {[`FPM_MAXON_CYC - 4 : `FPM_MAXON_CYC]}, 1'b1)
    u_pm.armed <= 1'b1;
    cyc(5);
    `CHK(valley_timer_en, 1'b0)
    drive_request <= 1'b1;
    cyc(10);
    `CHK(gate_drive_pulse, 1'b0)
    u_pm.detect <= 1'b1;
    cyc(6);
    `CHK(gate_drive_pulse, 1'b1)
    u_pm.armed <= 1'b0;
    cyc(5);
    `CHK(valley_timer_en, 1'b1)
    drive_request <= 1'b0;
    u_pm.detect <= 1'b0;
    cyc(5);
    $display("test gate timing done");
  endtask : t_gate
  task t_pin;
    u_pm.pin_mv <= 3500;
    cyc(500);
    u_pm.pin_mv <= 1500;
    cyc(100);
    `CHK(controller_on, 1'b1)
    u_pm.pin_mv <= 3500;
    cyc(550);
    `CHK(controller_on, 1'b1)
    expect_on(1'b0, 100);
    state_is(ST_LATCHED);
    u_pm.pin_mv <= 1500;
    toggle_start();
    cyc(20);
    `CHK(controller_on, 1'b0)
    u_pm.lremove <= 1'b1;
    cyc(4);
    u_pm.lremove <= 1'b0;
    expect_on(1'b1, 20);
    drive_request <= 1'b1;
    cyc(3);
    `CHK(gate_drive_pulse, 1'b1)
    u_pm.ovp <= 1'b1;
    cyc(5);
    `CHK(gate_drive_pulse, 1'b0)
    drive_request <= 1'b0;
    u_pm.ovp <= 1'b0;
    toggle_start();
    cyc(20);
    `CHK(controller_on, 1'b0)
    state_is(ST_LATCHED);
    run_up();
    $display("test latching faults done");
  endtask : t_pin
  task t_die;
    u_pm.hot <= 1'b1;
    expect_on(1'b0, 10);
    u_pm.hot <= 1'b0;
    cyc(20);
    `CHK(controller_on, 1'b0)
    u_pm.cooled <= 1'b1;
    expect_on(1'b1, 20);
    u_pm.cooled <= 1'b0;
    u_pm.hot <= 1'b1;
    expect_on(1'b0, 10);
    u_pm.hot <= 1'b0;
    u_pm.lremove <= 1'b1;
    cyc(4);
    u_pm.lremove <= 1'b0;
    expect_on(1'b1, 20);
    u_pm.csopen <= 1'b1;
    expect_on(1'b0, 10);
    u_pm.csopen <= 1'b0;
    expect_on(1'b1, 20);
    $display("test non-latching faults done");
  endtask : t_die
  task t_abnormal_overcurrent_detect;
    u_pm.abnormal_overcurrent_detect <= 1'b1;
    repeat (5) pulse(4);
    `CHK(controller_on, 1'b1)
    repeat (3) pulse(10);
    u_pm.abnormal_overcurrent_detect <= 1'b0;
    pulse(10);
    u_pm.abnormal_overcurrent_detect <= 1'b1;
    repeat (3) pulse(10);
    `CHK(controller_on, 1'b1)
    pulse(10);
    expect_on(1'b0, 10);
    state_is(ST_LATCHED);
    u_pm.abnormal_overcurrent_detect <= 1'b0;
    run_up();
    $display("test abnormal current done");
  endtask : t_abnormal_overcurrent_detect
  task t_ovld;
    u_pm.ovld <= 1'b1;
    cyc(150);
    u_pm.ovld <= 1'b0;
    cyc(150);
    u_pm.ovld <= 1'b1;
    cyc(150);
    `CHK(controller_on, 1'b1)
    expect_on(1'b0, 100);
    u_pm.ovld <= 1'b0;
    state_is(ST_RECOVER);
    cyc(320);
    `CHK(controller_on, 1'b0)
    toggle_start();
    expect_on(1'b1, 20);
    apb(1'b1, `FPM_CTRL_OFS, 32'h00000002);
    u_pm.ovld <= 1'b1;
    expect_on(1'b0, 250);
    u_pm.ovld <= 1'b0;
    state_is(ST_LATCHED);
    run_up();
    $display("test overload done");
  endtask : t_ovld
  task t_otp;
    apb(1'b1, `FPM_CTRL_OFS, 32'h00000001);
    u_pm.start <= 1'b0;
    u_pm.sreset <= 1'b1;
    cyc(4);
    u_pm.sreset <= 1'b0;
    cyc(4);
    `CHK(overtemp_pullup_source, 1'b0)
    soft_start_active <= 1'b1;
    u_pm.pin_mv <= 200;
    u_pm.start <= 1'b1;
    expect_on(1'b1, 20);
    cyc(800);
    `CHK(controller_on, 1'b1)
    soft_start_active <= 1'b0;
    expect_on(1'b0, 700);
    state_is(ST_LATCHED);
    u_pm.pin_mv <= 1500;
    apb(1'b1, `FPM_CTRL_OFS, 32'h0);
    run_up();
    u_pm.pin_mv <= 200;
    expect_on(1'b0, 700);
    cyc(320);
    u_pm.pin_mv <= 1500;
    cyc(5);
    toggle_start();
    expect_on(1'b1, 40);
    $display("test fault pin over-temperature done");
  endtask : t_otp
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    cyc(4);
    reset_n <= 1'b1;
    cyc(1);
    t_regs();
    t_gate();
    t_pin();
    t_die();
    t_abnormal_overcurrent_detect();
    t_ovld();
    t_otp();
    final_report();
  end
  initial begin
    cyc(40000);
    failures++;
    final_report();
  end
endmodule : tb_top
`default_nettype wire
